//--- logic/channel_flags.sv
// Per-channel output-voltage and output-current flag bytes.
// Assumes clears are already qualified by the selected page.
`timescale 1ns/10ps
`include "status_bank_consts.svh"
module channel_flags (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Events and clears
    input wire status_bank_pkg::channel_events_type events_in,
    input wire logic [7:0] vout_clear_in,
    input wire logic [7:0] iout_clear_in,
    input wire logic clear_all_in,
    // Flag bytes
    output logic [7:0] vout_flags_out,
    output logic [7:0] iout_flags_out
);
    logic [7:0] vout_set;
    logic [7:0] iout_set;

    // Event to bit placement
    always_comb begin
        vout_set = 8'h00;
        iout_set = 8'h00;
        vout_set[`VOUT_OVF_BIT] = events_in.vout_ov;
        vout_set[`VOUT_UVF_BIT] = events_in.vout_uv;
        vout_set[`VOUT_LIMIT_BIT] = events_in.vout_limit;
        iout_set[`IOUT_OCF_BIT] = events_in.iout_oc;
        iout_set[`IOUT_OCW_BIT] = events_in.iout_ocw;
        iout_set[`IOUT_SHARE_BIT] = events_in.iout_share;
    end

    flag_byte #(.SUPPORTED_MASK(`VOUT_MASK)) vout_byte (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(vout_set),
        .clear_in(vout_clear_in),
        .clear_all_in(clear_all_in),
        .flags_out(vout_flags_out)
    );

    flag_byte #(.SUPPORTED_MASK(`IOUT_MASK)) iout_byte (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(iout_set),
        .clear_in(iout_clear_in),
        .clear_all_in(clear_all_in),
        .flags_out(iout_flags_out)
    );
endmodule : channel_flags

//--- logic/flag_byte.sv
// One byte of latched flags with write-one-to-clear.
// Assumes set pulses and clear requests synchronous to clk_in.
`timescale 1ns/10ps
`include "status_bank_consts.svh"
module flag_byte #(
    parameter logic [7:0] SUPPORTED_MASK = 8'hFF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Flag control
    input wire logic [7:0] set_in,
    input wire logic [7:0] clear_in,
    input wire logic clear_all_in,
    // Flag state
    output logic [7:0] flags_out
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;

    // Set wins over clear so an event in the clearing cycle is kept
    assign flags_next = ((flags_reg & ~clear_in & {8{~clear_all_in}}) | set_in) & SUPPORTED_MASK;
    assign flags_out = flags_reg;

    // Flag storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg <= `FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end
endmodule : flag_byte

//--- logic/pmbus_fault_status_bank.sv
// Fault and status register bank for a dual-channel controller.
// Assumes a PMBus command decoder presents one access per cycle as a request
// struct and takes read data one cycle later; monitors pulse events.
`timescale 1ns/10ps
`include "status_bank_consts.svh"
module pmbus_fault_status_bank (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register access
    input wire status_bank_pkg::access_req_type req_in,
    input wire logic [7:0] page_in,
    input wire logic clear_all_in,
    // Monitor events
    input wire status_bank_pkg::channel_events_type chan_a_events_in,
    input wire status_bank_pkg::channel_events_type chan_b_events_in,
    input wire status_bank_pkg::input_events_type input_events_in,
    // Raw channel state
    input wire status_bank_pkg::channel_raw_type chan_a_raw_in,
    input wire status_bank_pkg::channel_raw_type chan_b_raw_in,
    // Read answer
    output logic [15:0] read_data_out,
    output logic read_valid_out,
    output logic invalid_access_out,
    // Summary words for both channels
    output logic [15:0] chan_a_word_out,
    output logic [15:0] chan_b_word_out
);
    logic [7:0] vout_a;
    logic [7:0] iout_a;
    logic [7:0] vout_b;
    logic [7:0] iout_b;
    logic [7:0] input_flags;
    logic [7:0] input_set;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic is_write;
    logic sel_b;
    logic hit_vout;
    logic hit_iout;
    logic hit_input;
    logic hit_word;
    logic [7:0] clr_data;
    logic [7:0] vout_clr_a;
    logic [7:0] vout_clr_b;
    logic [7:0] iout_clr_a;
    logic [7:0] iout_clr_b;
    logic [7:0] input_clr;
    logic [15:0] read_next;
    logic invalid_next;
    logic [15:0] read_data_reg;
    logic read_valid_reg;
    logic invalid_reg;
    logic [15:0] word_a_reg;
    logic [15:0] word_b_reg;

    // Builds one channel's summary word from its detailed bytes
    function automatic logic [15:0] summary(
        input logic [7:0] vout,
        input logic [7:0] iout,
        input logic [7:0] inp,
        input status_bank_pkg::channel_raw_type raw
    );
        logic [15:0] w;
        w = `WORD_RESET; // Bits 10..7 stay zero
        w[`SUM_VOUT_BIT] = |vout;
        w[`SUM_IOUT_BIT] = |iout;
        w[`SUM_INPUT_BIT] = |inp;
        w[`SUM_MFR_BIT] = raw.mfr_fault;
        w[`SUM_PGOOD_BIT] = ~raw.ready_pin;
        w[`SUM_OFF_BIT] = raw.power_off;
        w[`SUM_VOUT_OV_BIT] = vout[`VOUT_OVF_BIT];
        w[`SUM_IOUT_OC_BIT] = iout[`IOUT_OCF_BIT];
        w[`SUM_VIN_UV_BIT] = inp[`VIN_UVF_BIT];
        w[`SUM_TEMP_BIT] = raw.temp_fault;
        w[`SUM_CML_BIT] = raw.cml_fault;
        // Anything latched that bits 7..1 do not name
        w[`SUM_OTHER_BIT] = vout[`VOUT_UVF_BIT] | vout[`VOUT_LIMIT_BIT] | iout[`IOUT_OCW_BIT]
            | iout[`IOUT_SHARE_BIT] | (inp & ~(8'h01 << `VIN_UVF_BIT)) != 8'h00;
        return w;
    endfunction : summary

    // Command and page decode; any page other than 01h acts on channel A
    assign is_write = req_in.valid & req_in.write;
    assign sel_b = (page_in == `PAGE_CHANNEL_B);
    assign hit_word = req_in.command == `CMD_SUMMARY_WORD;
    assign hit_vout = req_in.command == `CMD_VOUT_FLAGS;
    assign hit_iout = req_in.command == `CMD_IOUT_FLAGS;
    assign hit_input = req_in.command == `CMD_INPUT_FLAGS;

    // Write-one-to-clear steering; zeros in the data clear nothing
    assign clr_data = is_write ? req_in.data : 8'h00;
    assign vout_clr_a = (hit_vout & ~sel_b) ? clr_data : 8'h00;
    assign vout_clr_b = (hit_vout & sel_b) ? clr_data : 8'h00;
    assign iout_clr_a = (hit_iout & ~sel_b) ? clr_data : 8'h00;
    assign iout_clr_b = (hit_iout & sel_b) ? clr_data : 8'h00;
    assign input_clr = hit_input ? clr_data : 8'h00; // Page ignored

    // Input event placement
    always_comb begin
        input_set = 8'h00;
        input_set[`VIN_OVF_BIT] = input_events_in.vin_ov;
        input_set[`VIN_UVF_BIT] = input_events_in.vin_uv;
        input_set[`VIN_LOW_BIT] = input_events_in.vin_low;
        input_set[`IIN_OCF_BIT] = input_events_in.iin_oc;
        input_set[`IIN_OCW_BIT] = input_events_in.iin_ocw;
        input_set[`PIN_OPW_BIT] = input_events_in.pin_opw;
    end

    channel_flags chan_a (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .events_in(chan_a_events_in),
        .vout_clear_in(vout_clr_a),
        .iout_clear_in(iout_clr_a),
        .clear_all_in(clear_all_in),
        .vout_flags_out(vout_a),
        .iout_flags_out(iout_a)
    );

    channel_flags chan_b (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .events_in(chan_b_events_in),
        .vout_clear_in(vout_clr_b),
        .iout_clear_in(iout_clr_b),
        .clear_all_in(clear_all_in),
        .vout_flags_out(vout_b),
        .iout_flags_out(iout_b)
    );

    // Single shared copy of the input flags
    flag_byte #(.SUPPORTED_MASK(`INPUT_MASK)) input_byte (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(input_set),
        .clear_in(input_clr),
        .clear_all_in(clear_all_in),
        .flags_out(input_flags)
    );

    // Summary words follow the detailed bytes combinationally
    assign word_a = summary(vout_a, iout_a, input_flags, chan_a_raw_in);
    assign word_b = summary(vout_b, iout_b, input_flags, chan_b_raw_in);

    // Read mux; an unknown command reads zero and is flagged invalid
    always_comb begin
        read_next = 16'h0000;
        invalid_next = 1'b0;
        if (req_in.valid) begin
            if (hit_word) begin
                read_next = sel_b ? word_b : word_a;
                invalid_next = req_in.write; // Word left untouched
            end else if (hit_vout) begin
                read_next = {8'h00, sel_b ? vout_b : vout_a};
            end else if (hit_iout) begin
                read_next = {8'h00, sel_b ? iout_b : iout_a};
            end else if (hit_input) begin
                read_next = {8'h00, input_flags};
            end else begin
                invalid_next = 1'b1;
            end
        end
    end

    // Answer registers; writes answer with neither valid nor data
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_data_reg <= `WORD_RESET;
            read_valid_reg <= 1'b0;
            invalid_reg <= 1'b0;
        end else begin
            read_data_reg <= req_in.write ? `WORD_RESET : read_next;
            read_valid_reg <= req_in.valid & ~req_in.write;
            invalid_reg <= invalid_next;
        end
    end

    // Registered copies of both summary words for status pins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_a_reg <= `WORD_RESET;
            word_b_reg <= `WORD_RESET;
        end else begin
            word_a_reg <= word_a;
            word_b_reg <= word_b;
        end
    end

    assign read_data_out = read_data_reg;
    assign read_valid_out = read_valid_reg;
    assign invalid_access_out = invalid_reg;
    assign chan_a_word_out = word_a_reg;
    assign chan_b_word_out = word_b_reg;
endmodule : pmbus_fault_status_bank

//--- logic/status_bank_consts.svh
// Offsets, field positions, masks and reset values of the status register bank.
// Assumes inclusion by bare name from the design modules.
`ifndef STATUS_BANK_CONSTS_SVH
`define STATUS_BANK_CONSTS_SVH

// Command codes of the status registers
`define CMD_SUMMARY_WORD 8'h79
`define CMD_VOUT_FLAGS 8'h7A
`define CMD_IOUT_FLAGS 8'h7B
`define CMD_INPUT_FLAGS 8'h7C

// Page values
`define PAGE_CHANNEL_A 8'h00
`define PAGE_CHANNEL_B 8'h01
`define PAGE_ALL 8'hFF

// Output-voltage flag positions
`define VOUT_OVF_BIT 7
`define VOUT_UVF_BIT 4
`define VOUT_LIMIT_BIT 3
// Output-current flag positions
`define IOUT_OCF_BIT 7
`define IOUT_OCW_BIT 5
`define IOUT_SHARE_BIT 3
// Input flag positions
`define VIN_OVF_BIT 7
`define VIN_UVF_BIT 4
`define VIN_LOW_BIT 3
`define IIN_OCF_BIT 2
`define IIN_OCW_BIT 1
`define PIN_OPW_BIT 0

// Supported-bit masks
`define VOUT_MASK 8'h98
`define IOUT_MASK 8'hA8
`define INPUT_MASK 8'h9F

// Summary word positions
`define SUM_VOUT_BIT 15
`define SUM_IOUT_BIT 14
`define SUM_INPUT_BIT 13
`define SUM_MFR_BIT 12
`define SUM_PGOOD_BIT 11
`define SUM_OFF_BIT 6
`define SUM_VOUT_OV_BIT 5
`define SUM_IOUT_OC_BIT 4
`define SUM_VIN_UV_BIT 3
`define SUM_TEMP_BIT 2
`define SUM_CML_BIT 1
`define SUM_OTHER_BIT 0

// Reset values
`define FLAGS_RESET 8'h00
`define WORD_RESET 16'h0000

`endif

//--- logic/status_bank_pkg.sv
// Types shared by the status bank modules.
// Assumes the constants header is on the include path.
package status_bank_pkg;

    // One channel's fault and warning events, one-cycle pulses
    typedef struct packed {
        logic vout_ov;
        logic vout_uv;
        logic vout_limit;
        logic iout_oc;
        logic iout_ocw;
        logic iout_share;
    } channel_events_type;

    // Shared input-supply events
    typedef struct packed {
        logic vin_ov;
        logic vin_uv;
        logic vin_low;
        logic iin_oc;
        logic iin_ocw;
        logic pin_opw;
    } input_events_type;

    // Raw per-channel state feeding unlatched and foreign summary bits
    typedef struct packed {
        logic ready_pin;
        logic power_off;
        logic mfr_fault;
        logic temp_fault;
        logic cml_fault;
    } channel_raw_type;

    // Register access request from the command decoder
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] command;
        logic [7:0] data;
    } access_req_type;

endpackage : status_bank_pkg

//--- testbench/pmbus_fault_status_bank_test.sv
// Self-checking bench for the status register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module pmbus_fault_status_bank_test;
    logic clk_in;
    logic rst_n_in;
    logic clear_all_in;
    status_bank_pkg::access_req_type req;
    logic [7:0] page;
    status_bank_pkg::channel_events_type ev_a, ev_b;
    status_bank_pkg::input_events_type ev_i;
    status_bank_pkg::channel_raw_type raw_a, raw_b;
    logic [15:0] rdata, word_a, word_b;
    logic rvalid, bad;
    int n_errors = 0;
    int cmp_count = 0;

    pmbus_fault_status_bank u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .page_in(page),
        .clear_all_in(clear_all_in), .chan_a_events_in(ev_a), .chan_b_events_in(ev_b), .input_events_in(ev_i),
        .chan_a_raw_in(raw_a), .chan_b_raw_in(raw_b), .read_data_out(rdata), .read_valid_out(rvalid),
        .invalid_access_out(bad), .chan_a_word_out(word_a), .chan_b_word_out(word_b));
    status_host_model u_host (.clk_in(clk_in), .read_data_in(rdata), .read_valid_in(rvalid), .invalid_in(bad),
        .req_out(req), .page_out(page));

    // 125 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // Verdict and end of run
    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // One access against its expected {invalid, valid, data}
    task automatic acc(input logic wr, input logic [7:0] pg, input logic [7:0] cmd, input logic [7:0] dat,
                       input logic [17:0] exp);
        logic [15:0] rd;
        logic ok, nok;
        u_host.xfer(wr, pg, cmd, dat, rd, ok, nok);
        `CHK({nok, ok, rd}, exp)
    endtask : acc

    // One-cycle monitor events
    task automatic pulse(input logic [5:0] a, input logic [5:0] i);
        @(negedge clk_in);
        ev_a = a;
        ev_i = i;
        @(negedge clk_in);
        ev_a = '0;
        ev_i = '0;
    endtask : pulse

    // Hang guard
    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        clear_all_in = 1'b0;
        ev_a = '0;
        ev_b = '0;
        ev_i = '0;
        raw_a = 5'b11000; // Ready high, output off
        raw_b = 5'b11111; // Ready high, output off, foreign faults set
        repeat (4) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge clk_in);
        `CHK(word_a, 16'h0040)
        `CHK(word_b, 16'h1046)
        acc(0, 8'h00, 8'h7A, 8'h00, 18'h1_0000);
        raw_a = 5'b00000;
        pulse(6'h3F, 6'h00);
        acc(0, 8'hFF, 8'h79, 8'h00, 18'h1_C831);
        acc(0, 8'h00, 8'h7A, 8'h00, 18'h1_0098);
        acc(0, 8'h00, 8'h7B, 8'h00, 18'h1_00A8);
        acc(0, 8'h01, 8'h7A, 8'h00, 18'h1_0000);
        acc(1, 8'h00, 8'h7A, 8'h67, 18'h0_0000);
        acc(0, 8'h00, 8'h7A, 8'h00, 18'h1_0098);
        acc(1, 8'h00, 8'h7A, 8'h80, 18'h0_0000);
        acc(0, 8'h00, 8'h7A, 8'h00, 18'h1_0018);
        acc(1, 8'h00, 8'h7B, 8'hA8, 18'h0_0000);
        acc(0, 8'h00, 8'h79, 8'h00, 18'h1_8801);
        acc(1, 8'h00, 8'h79, 8'hFF, 18'h2_0000);
        acc(0, 8'h00, 8'h79, 8'h00, 18'h1_8801);
        acc(1, 8'h00, 8'h7D, 8'hFF, 18'h2_0000);
        acc(0, 8'h00, 8'h7E, 8'h00, 18'h3_0000);
        pulse(6'h00, 6'h3F);
        acc(0, 8'h01, 8'h7C, 8'h00, 18'h1_009F);
        acc(1, 8'h01, 8'h7C, 8'h1F, 18'h0_0000);
        acc(0, 8'h00, 8'h7C, 8'h00, 18'h1_0080);
        `CHK(word_b, 16'h3047)
        ev_b = 6'h04; // Overcurrent still present during the clear
        acc(1, 8'h01, 8'h7B, 8'h80, 18'h0_0000);
        ev_b = '0;
        raw_b = 5'b10000; // Ready high, raw faults gone, so stuck summary bits show
        acc(0, 8'h01, 8'h7B, 8'h00, 18'h1_0080);
        @(negedge clk_in);
        clear_all_in = 1'b1;
        @(negedge clk_in);
        clear_all_in = 1'b0;
        acc(0, 8'h01, 8'h7B, 8'h00, 18'h1_0000);
        acc(0, 8'h00, 8'h7C, 8'h00, 18'h1_0000);
        `CHK(word_a, 16'h0800)
        `CHK(word_b, 16'h0000)
        conclude();
    end
endmodule : pmbus_fault_status_bank_test

//--- testbench/status_bank_chk.sv
// Port assertions for the status register bank.
// Assumes it is bound to the bank top, one clock domain.
`timescale 1ns/10ps
module status_bank_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Stimulus side
    input wire status_bank_pkg::access_req_type req_in,
    input wire logic clear_all_in,
    input wire status_bank_pkg::channel_events_type chan_a_events_in,
    input wire status_bank_pkg::channel_events_type chan_b_events_in,
    input wire status_bank_pkg::input_events_type input_events_in,
    input wire status_bank_pkg::channel_raw_type chan_a_raw_in,
    input wire status_bank_pkg::channel_raw_type chan_b_raw_in,
    // Answer side
    input wire logic read_valid_out,
    input wire logic invalid_access_out,
    input wire logic [15:0] chan_a_word_out,
    input wire logic [15:0] chan_b_word_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Causes allowed to drop channel A voltage summary; page ignored, so looser
    wire vout_clr = clear_all_in || (req_in.valid && req_in.write && req_in.command == 8'h7A);
    property p_rd_ans;
        req_in.valid && !req_in.write && req_in.command inside {[8'h79:8'h7C]} |=> read_valid_out && !invalid_access_out;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_wr_word;
        req_in.valid && req_in.write && req_in.command == 8'h79 |=> invalid_access_out && !read_valid_out;
    endproperty
    a_wr_word: assert property (p_wr_word) else $error("summary write accepted");
    property p_spare;
        chan_a_word_out[10:7] == 4'h0 && chan_b_word_out[10:7] == 4'h0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare summary bit set");
    // Two-cycle guard: words may still be clear at the first edge after reset
    property p_ready;
        $past(rst_n_in, 2) |-> chan_a_word_out[11] == !$past(chan_a_raw_in.ready_pin);
    endproperty
    a_ready: assert property (p_ready) else $error("ready bit wrong");
    property p_off;
        $past(rst_n_in, 2) |-> chan_b_word_out[6] == $past(chan_b_raw_in.power_off);
    endproperty
    a_off: assert property (p_off) else $error("off bit wrong");
    property p_mfr;
        $past(rst_n_in, 2) |-> chan_b_word_out[12] == $past(chan_b_raw_in.mfr_fault);
    endproperty
    a_mfr: assert property (p_mfr) else $error("mfr bit wrong");
    property p_vout;
        chan_a_events_in.vout_ov |-> ##2 chan_a_word_out[15] && chan_a_word_out[5];
    endproperty
    a_vout: assert property (p_vout) else $error("overvoltage not summarised");
    property p_iout;
        chan_b_events_in.iout_oc |-> ##2 chan_b_word_out[14] && chan_b_word_out[4];
    endproperty
    a_iout: assert property (p_iout) else $error("overcurrent not summarised");
    property p_input;
        input_events_in.vin_uv |-> ##2 chan_a_word_out[13] && chan_b_word_out[3];
    endproperty
    a_input: assert property (p_input) else $error("input flag not shared");
    property p_other;
        chan_a_events_in.vout_uv |-> ##2 chan_a_word_out[0];
    endproperty
    a_other: assert property (p_other) else $error("other bit missing");
    property p_hold;
        $fell(chan_a_word_out[15]) |-> $past(vout_clr, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped unasked");
    // Main scenarios
    c_clear: cover property ($fell(chan_a_word_out[15]));
    c_invalid: cover property (invalid_access_out);
    c_input: cover property (chan_b_word_out[13]);
endmodule : status_bank_chk

bind pmbus_fault_status_bank status_bank_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .clear_all_in(clear_all_in), .chan_a_events_in(chan_a_events_in), .chan_b_events_in(chan_b_events_in),
    .input_events_in(input_events_in), .chan_a_raw_in(chan_a_raw_in), .chan_b_raw_in(chan_b_raw_in),
    .read_valid_out(read_valid_out), .invalid_access_out(invalid_access_out),
    .chan_a_word_out(chan_a_word_out), .chan_b_word_out(chan_b_word_out));

//--- testbench/status_host_model.sv
// Host model issuing status register accesses.
// Assumes requests taken at the rising edge, answer one cycle later.
`timescale 1ns/10ps
module status_host_model (
    // Clock
    input wire logic clk_in,
    // Answer from the bank
    input wire logic [15:0] read_data_in,
    input wire logic read_valid_in,
    input wire logic invalid_in,
    // Request to the bank
    output status_bank_pkg::access_req_type req_out,
    output logic [7:0] page_out
);
    // Idle bus at time zero
    initial begin
        req_out = '0;
        page_out = 8'h00;
    end
    // One transfer; idle fields inverted so nothing stale passes for a request
    task automatic xfer(input logic wr, input logic [7:0] pg, input logic [7:0] cmd, input logic [7:0] dat,
                        output logic [15:0] rd, output logic ok, output logic bad);
        @(negedge clk_in);
        page_out = pg;
        req_out = {1'b1, wr, cmd, dat};
        @(negedge clk_in);
        rd = read_data_in;
        ok = read_valid_in;
        bad = invalid_in;
        req_out = {1'b0, ~wr, ~cmd, ~dat};
    endtask : xfer
endmodule : status_host_model
